// File: verilog/rsc_consts.svh
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses, one receive control register per channel
// ----------------------------------------------------------------
`define RSC_ADDR_CH0 8'h05
`define RSC_ADDR_CH1 8'h0D
`define RSC_ADDR_CH2 8'h15

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSC_BIT_DIG_DET_DIS 5
`define RSC_BIT_ANA_DET_DIS 4
`define RSC_BIT_CLK_INV 3
`define RSC_BIT_MUTE 2
`define RSC_BIT_MONITOR 1
`define RSC_BIT_EQ_EN 0

// ----------------------------------------------------------------
// reset value and writable bits
// ----------------------------------------------------------------
`define RSC_RESET_VAL 8'h00
`define RSC_WR_MASK 8'h3F
`define RSC_NUM_CH 3

`endif

// File: verilog/rsc_pkg.sv
package rsc_pkg;

	// line rate the channel is configured for
	typedef enum logic [1:0] {
		RSC_MODE_E3,
		RSC_MODE_DS3,
		RSC_MODE_STS1
	} rsc_line_mode_e;

	// one receive control register
	typedef logic [7:0] rsc_ctrl_t;

endpackage

// File: verilog/rsc_rx_channel.sv
`timescale 1ns/100ps
`include "rsc_consts.svh"

module rsc_rx_channel (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// settings from the control register
	input wire rsc_pkg::rsc_ctrl_t ctrl,
	input wire rsc_pkg::rsc_line_mode_e line_mode,
	// raw detector and recovery inputs
	input wire logic digital_signal_loss_raw,
	input wire logic analog_signal_loss_raw,
	input wire logic recovered_clock_in,
	input wire logic recovered_positive_in,
	input wire logic recovered_negative_in,
	// outputs toward the framer and analog front end
	output logic recovered_clock_out,
	output logic recovered_positive_data,
	output logic recovered_negative_data,
	output logic signal_loss_defect,
	output logic digital_signal_loss_detector_en,
	output logic analog_signal_loss_detector_en,
	output logic equalizer_en
);

	logic e3_mode;
	logic dig_en;
	logic ana_en;
	logic defect_d;
	logic launch;
	logic rclk_q;
	logic defect_q;
	logic pos_q;
	logic neg_q;

	// ----------------------------------------------------------------
	// detector enables
	// ----------------------------------------------------------------
	// disable fields only count outside e3 operation
	assign e3_mode = (line_mode == rsc_pkg::RSC_MODE_E3);
	assign dig_en = e3_mode | ~ctrl[`RSC_BIT_DIG_DET_DIS];
	assign ana_en = e3_mode | ~ctrl[`RSC_BIT_ANA_DET_DIS];
	assign digital_signal_loss_detector_en = dig_en;
	assign analog_signal_loss_detector_en = ana_en;
	assign equalizer_en = ctrl[`RSC_BIT_EQ_EN];

	// monitor mode holds the defect off whatever the detectors see
	assign defect_d = ~ctrl[`RSC_BIT_MONITOR]
		& ((dig_en & digital_signal_loss_raw) | (ana_en & analog_signal_loss_raw));

	// ----------------------------------------------------------------
	// defect flag
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			defect_q <= 1'b0;
		end else begin
			defect_q <= defect_d;
		end
	end
	assign signal_loss_defect = defect_q;

	// ----------------------------------------------------------------
	// recovered clock, delayed one cycle so data edges line up
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rclk_q <= 1'b0;
		end else begin
			rclk_q <= recovered_clock_in;
		end
	end
	assign recovered_clock_out = rclk_q;

	// launch on the rising edge, or the falling one when inverted
	assign launch = ctrl[`RSC_BIT_CLK_INV] ? (rclk_q & ~recovered_clock_in)
		: (~rclk_q & recovered_clock_in);

	// ----------------------------------------------------------------
	// recovered data launch and mute
	// ----------------------------------------------------------------
	// muting acts every cycle, not only at launch, so no stale one survives
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end else if (ctrl[`RSC_BIT_MUTE] && defect_d) begin
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end else if (launch) begin
			pos_q <= recovered_positive_in;
			neg_q <= recovered_negative_in;
		end
	end
	assign recovered_positive_data = pos_q;
	assign recovered_negative_data = neg_q;

endmodule

// File: verilog/rsc_receive_control.sv
`timescale 1ns/100ps
`include "rsc_consts.svh"

// Operation
// - digital detector off when bit 5 set
// - analog detector off when bit 4 set
// - disable bits act only in DS3/STS-1
// - bit 3 picks recovered clock launch edge
// - bit 2 mutes data during signal loss
// - bit 1 monitor mode suppresses signal loss
// - bit 0 clear disables equalizer
// - bit 0 set enables equalizer

module rsc_receive_control (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register access port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// per-channel line configuration
	input wire rsc_pkg::rsc_line_mode_e line_mode [`RSC_NUM_CH],
	// per-channel detector and recovery inputs
	input wire logic [`RSC_NUM_CH-1:0] digital_signal_loss_raw,
	input wire logic [`RSC_NUM_CH-1:0] analog_signal_loss_raw,
	input wire logic [`RSC_NUM_CH-1:0] recovered_clock_in,
	input wire logic [`RSC_NUM_CH-1:0] recovered_positive_in,
	input wire logic [`RSC_NUM_CH-1:0] recovered_negative_in,
	// per-channel outputs to the framer
	output logic [`RSC_NUM_CH-1:0] recovered_clock_out,
	output logic [`RSC_NUM_CH-1:0] recovered_positive_data,
	output logic [`RSC_NUM_CH-1:0] recovered_negative_data,
	output logic [`RSC_NUM_CH-1:0] signal_loss_defect,
	// per-channel controls to the analog front end
	output logic [`RSC_NUM_CH-1:0] digital_signal_loss_detector_en,
	output logic [`RSC_NUM_CH-1:0] analog_signal_loss_detector_en,
	output logic [`RSC_NUM_CH-1:0] equalizer_en
);

	rsc_pkg::rsc_ctrl_t ctrl_q [`RSC_NUM_CH];
	logic [`RSC_NUM_CH-1:0] sel;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// any other address is unmapped: writes dropped, reads give zero
	assign sel[0] = (reg_addr == `RSC_ADDR_CH0);
	assign sel[1] = (reg_addr == `RSC_ADDR_CH1);
	assign sel[2] = (reg_addr == `RSC_ADDR_CH2);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// upper bits never store, so they cannot leak back on a read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `RSC_NUM_CH; i++) begin
				ctrl_q[i] <= `RSC_RESET_VAL;
			end
		end else if (reg_wr) begin
			for (int i = 0; i < `RSC_NUM_CH; i++) begin
				if (sel[i]) begin
					ctrl_q[i] <= reg_wdata & `RSC_WR_MASK;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = 8'h00;
		for (int i = 0; i < `RSC_NUM_CH; i++) begin
			if (sel[i]) begin
				rdata_d = ctrl_q[i] & `RSC_WR_MASK;
			end
		end
	end

	// read data registered, one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end
	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	// ----------------------------------------------------------------
	// receive channels
	// ----------------------------------------------------------------
	for (genvar c = 0; c < `RSC_NUM_CH; c++) begin : g_ch
		rsc_rx_channel u_ch (
			.mclk(mclk),
			.rst_n(rst_n),
			.ctrl(ctrl_q[c]),
			.line_mode(line_mode[c]),
			.digital_signal_loss_raw(digital_signal_loss_raw[c]),
			.analog_signal_loss_raw(analog_signal_loss_raw[c]),
			.recovered_clock_in(recovered_clock_in[c]),
			.recovered_positive_in(recovered_positive_in[c]),
			.recovered_negative_in(recovered_negative_in[c]),
			.recovered_clock_out(recovered_clock_out[c]),
			.recovered_positive_data(recovered_positive_data[c]),
			.recovered_negative_data(recovered_negative_data[c]),
			.signal_loss_defect(signal_loss_defect[c]),
			.digital_signal_loss_detector_en(digital_signal_loss_detector_en[c]),
			.analog_signal_loss_detector_en(analog_signal_loss_detector_en[c]),
			.equalizer_en(equalizer_en[c])
		);
	end

endmodule

// File: bench/rsc_host_model.sv
`timescale 1ns/100ps
module rsc_host_model (
	// clock
	input wire logic mclk,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic reg_rvalid
);
	// bus idle from time zero
	initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
	// one strobe cycle, launched after an edge
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// bounded wait, so a dead port cannot hang the run
	task automatic rd(logic [7:0] a, output logic ok);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		ok = 1'b0;
		repeat (2) begin
			#1 ok = ok | (reg_rvalid === 1'b1);
			@(posedge mclk);
		end
	endtask
endmodule

// File: bench/rsc_receive_control_asserts.sv
`timescale 1ns/100ps
module rsc_receive_control_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// channel outputs
	input wire logic [2:0] recovered_clock_out,
	input wire logic [2:0] recovered_positive_data,
	input wire logic [2:0] signal_loss_defect,
	input wire logic [2:0] digital_signal_loss_detector_en,
	input wire logic [2:0] analog_signal_loss_detector_en,
	input wire logic [2:0] equalizer_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [7:0] shadow_q;
	// channel 0 settings as seen from host writes only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) shadow_q <= 8'h00;
		else if (reg_wr && reg_addr == 8'h05) shadow_q <= reg_wdata & 8'h3F;
	end
	sequence s_wr0; reg_wr && reg_addr == 8'h05; endsequence
	sequence s_rd0; !reg_wr && reg_rd && reg_addr == 8'h05; endsequence
	// reads answer with what the host last wrote, upper bits already cleared in the shadow
	a_read_back: assert property (s_rd0 |=> reg_rvalid && reg_rdata == shadow_q)
		else $error("read-back differs");
	a_upper_zero: assert property (reg_rvalid |-> reg_rdata[7:6] == 2'b00)
		else $error("upper bits set");
	a_rvalid_next: assert property (reg_rd |=> reg_rvalid)
		else $error("no read answer");
	a_eq_write: assert property (s_wr0 |=> equalizer_en[0] == $past(reg_wdata[0]))
		else $error("equalizer enable wrong");
	a_dig_off: assert property (!digital_signal_loss_detector_en[0] |-> shadow_q[5])
		else $error("digital detector off");
	a_ana_off: assert property (!analog_signal_loss_detector_en[0] |-> shadow_q[4])
		else $error("analog detector off");
	a_mute_loss: assert property (signal_loss_defect[0] && $past(shadow_q[2]) |->
		!recovered_positive_data[0]) else $error("data not muted");
	a_monitor_quiet: assert property ($past(shadow_q[1]) |-> !signal_loss_defect[0])
		else $error("defect in monitor mode");
	a_launch_edge: assert property ($changed(recovered_positive_data[0]) &&
		!signal_loss_defect[0] |-> $changed(recovered_clock_out[0]) &&
		recovered_clock_out[0] != $past(shadow_q[3])) else $error("wrong launch edge");
endmodule
bind rsc_receive_control rsc_receive_control_asserts u_asserts (.mclk, .rst_n, .reg_addr,
	.reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .recovered_clock_out,
	.recovered_positive_data, .signal_loss_defect, .digital_signal_loss_detector_en,
	.analog_signal_loss_detector_en, .equalizer_en);

// File: bench/tb_top.sv
`timescale 1ns/100ps
`include "rsc_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_top;
	logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, rv_x, term, launch, ok;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_x;
	rsc_pkg::rsc_line_mode_e line_mode [`RSC_NUM_CH];
	logic [2:0] digital_signal_loss_raw, analog_signal_loss_raw, recovered_clock_in;
	logic [2:0] recovered_positive_in, recovered_negative_in, recovered_clock_out;
	logic [2:0] recovered_positive_data, recovered_negative_data, signal_loss_defect;
	logic [2:0] digital_signal_loss_detector_en, analog_signal_loss_detector_en, equalizer_en;
	logic [2:0] rc_q, pos_x, neg_x, los_x;
	logic [7:0] ctrl [3];
	logic [7:0] addr_tab [3] = '{`RSC_ADDR_CH0, `RSC_ADDR_CH1, `RSC_ADDR_CH2};
	logic [31:0] seed = 32'h8BFC6162, r, q;
	int num_errors = 0, checks = 0, i, c;
	rsc_host_model host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rvalid);
	rsc_receive_control dut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .reg_rvalid, .line_mode, .digital_signal_loss_raw, .analog_signal_loss_raw,
		.recovered_clock_in, .recovered_positive_in, .recovered_negative_in,
		.recovered_clock_out, .recovered_positive_data, .recovered_negative_data,
		.signal_loss_defect, .digital_signal_loss_detector_en, .analog_signal_loss_detector_en,
		.equalizer_en);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// E3 keeps detectors on whatever the disable bit says
	function automatic logic en(int ch, int b);
		return line_mode[ch] == rsc_pkg::RSC_MODE_E3 || !ctrl[ch][b];
	endfunction
	task automatic report_and_stop();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rd_chk(logic [7:0] a);
		host.rd(a, ok);
		if (!ok) begin
			$display("mismatch at %0t: no read answer", $time);
			num_errors++;
			report_and_stop();
		end
	endtask
	// random line activity; defects made rarer than data toggles
	always @(posedge mclk) if (rst_n) begin
		r = rnd();
		recovered_clock_in <= r[2:0];
		recovered_positive_in <= r[5:3];
		recovered_negative_in <= r[8:6];
		digital_signal_loss_raw <= r[11:9] & r[14:12];
		analog_signal_loss_raw <= r[17:15] & r[20:18];
	end
	// reference model, stepped on values sampled at each edge
	always begin
		@(posedge mclk);
		rv_x = reg_rd;
		rd_x = 8'h00;
		for (c = 0; c < 3; c++) begin
			term = !ctrl[c][1] && ((en(c, 5) && digital_signal_loss_raw[c]) ||
				(en(c, 4) && analog_signal_loss_raw[c]));
			launch = ctrl[c][3] ? rc_q[c] && !recovered_clock_in[c] : !rc_q[c] && recovered_clock_in[c];
			if (ctrl[c][2] && term) {pos_x[c], neg_x[c]} = 2'b00;
			else if (launch) {pos_x[c], neg_x[c]} = {recovered_positive_in[c], recovered_negative_in[c]};
			los_x[c] = term;
			rc_q[c] = recovered_clock_in[c];
			if (reg_rd && reg_addr == addr_tab[c]) rd_x = ctrl[c];
			if (reg_wr && reg_addr == addr_tab[c]) ctrl[c] = reg_wdata & `RSC_WR_MASK;
		end
		if (!rst_n) begin
			ctrl = '{default: `RSC_RESET_VAL};
			{rc_q, pos_x, neg_x, los_x, rv_x} = '0;
		end
		#1;
		`CHK(reg_rvalid, rv_x)
		if (rv_x) `CHK(reg_rdata, rd_x)
		for (c = 0; c < 3; c++) begin
			`CHK(recovered_clock_out[c], rc_q[c])
			`CHK({recovered_positive_data[c], recovered_negative_data[c]}, {pos_x[c], neg_x[c]})
			`CHK(signal_loss_defect[c], los_x[c])
			`CHK(digital_signal_loss_detector_en[c], en(c, 5))
			`CHK(analog_signal_loss_detector_en[c], en(c, 4))
			`CHK(equalizer_en[c], ctrl[c][0])
		end
	end
	initial begin
		rst_n = 1'b0;
		line_mode = '{default: rsc_pkg::RSC_MODE_E3};
		{digital_signal_loss_raw, analog_signal_loss_raw, recovered_clock_in} = '0;
		{recovered_positive_in, recovered_negative_in} = '0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(`RSC_ADDR_CH0);
		host.wr(8'h06, 8'hFF);
		for (i = 0; i < 30; i++) begin
			q = rnd();
			@(posedge mclk);
			line_mode[i % 3] <= rsc_pkg::rsc_line_mode_e'((i / 3) % 3);
			host.wr(addr_tab[i % 3], q[7:0]);
			rd_chk(addr_tab[i % 3]);
			rd_chk(q[15:8]);
			repeat (q[20:16]) @(posedge mclk);
		end
		report_and_stop();
	end
endmodule
